// [bench/ifa_drive_model.sv]
module ifa_drive_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic want_regen,
   input  wire logic want_demand,
   input  wire logic coast_or_brake_stop,
   input  wire logic regen_bridge_off,
   output logic      regenerating,
   output logic      regen_demand
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         regenerating <= 1'b0;
         regen_demand <= 1'b0;
      end else begin
         // Regen bridge conducts only while enabled
         regenerating <= want_regen && !regen_bridge_off
                         && !coast_or_brake_stop;
         // Demand ends once the drive is stopped
         regen_demand <= want_demand && !coast_or_brake_stop;
      end
   end
endmodule : ifa_drive_model

// [bench/ifa_supervisor_chk.sv]
module ifa_supervisor_chk #(
   parameter int GRACE_CYCLES = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic hazard,
   input wire logic regen_demand,
   input wire logic fault_reset,
   input wire logic force_ref_zero,
   input wire logic regen_bridge_off,
   input wire logic coast_or_brake_stop,
   input wire logic regen_hazard_event,
   input wire logic alarm_active
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned cnt;
   int unsigned next_cnt;
   always_comb begin
      next_cnt = 0;
      if (force_ref_zero && regen_demand && hazard)
         next_cnt = cnt + 1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn)
         cnt <= 0;
      else
         cnt <= next_cnt;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_trip;
      coast_or_brake_stop && !force_ref_zero;
   endsequence
   a_stop_latch: assert property (
      coast_or_brake_stop && !fault_reset |=> coast_or_brake_stop)
      else $error("stop released early");
   a_stop_event: assert property (
      $rose(coast_or_brake_stop) |-> regen_hazard_event)
      else $error("stop without event");
   a_alarm_event: assert property (
      $rose(alarm_active) |-> regen_hazard_event)
      else $error("alarm without event");
   a_zero_cause: assert property (
      $rose(force_ref_zero) |-> $past(hazard))
      else $error("zero reference without hazard");
   a_zero_bridge: assert property (
      force_ref_zero |-> regen_bridge_off)
      else $error("grace with regen bridge on");
   a_stop_alone: assert property (
      coast_or_brake_stop |-> !regen_bridge_off && !force_ref_zero)
      else $error("stop mixed with grace");
   a_grace_trip: assert property (
      cnt == GRACE_CYCLES - 2 |-> ##[0:4] s_trip)
      else $error("grace overrun");
   a_no_early: assert property (
      cnt > 0 && cnt + 3 < GRACE_CYCLES |=> !coast_or_brake_stop)
      else $error("early trip");
   a_clear_resume: assert property (
      regen_bridge_off && !hazard |=> !regen_bridge_off)
      else $error("bridge not re-enabled");
endmodule : ifa_supervisor_chk
bind ifa_supervisor ifa_supervisor_chk #(
   .GRACE_CYCLES(GRACE_CYCLES)
) u_chk (
   .aclk, .aresetn, .hazard, .regen_demand, .fault_reset,
   .force_ref_zero, .regen_bridge_off, .coast_or_brake_stop,
   .regen_hazard_event, .alarm_active
);

// [bench/inverting_fault_avoidance_tb.sv]
module inverting_fault_avoidance_tb
   import ifa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int G = 20;
   logic aclk, aresetn, hazard, regen_request, fault_reset, irq;
   logic want_regen, want_demand, regenerating, regen_demand;
   logic force_ref_zero, regen_bridge_off, coast_or_brake_stop;
   logic regen_hazard_event, alarm_active;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int fails, tests_run, n;
   wire logic [3:0] outs = {coast_or_brake_stop, force_ref_zero,
                            regen_bridge_off, alarm_active};
   ifa_supervisor #(.GRACE_CYCLES(G)) uut (
      .aclk, .aresetn, .hazard, .regenerating, .regen_request,
      .regen_demand, .fault_reset, .force_ref_zero, .regen_bridge_off,
      .coast_or_brake_stop, .regen_hazard_event, .alarm_active, .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready
   );
   ifa_drive_model u_drv (
      .aclk, .aresetn, .want_regen, .want_demand, .coast_or_brake_stop,
      .regen_bridge_off, .regenerating, .regen_demand
   );
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic cy(input int c);
      repeat (c) @(posedge aclk);
   endtask : cy
   task automatic tmo();
      if (n >= 50) begin
         fails++;
         print_verdict();
      end
   endtask : tmo
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      n = 0;
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      r = s_axi_bresp;
      tmo();
   endtask : wr
   task automatic rd(input logic [7:0] a);
      n = 0;
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      tmo();
   endtask : rd
   task automatic clr();
      {hazard, want_regen, want_demand, regen_request} <= 4'h0;
      fault_reset <= 1'b1;
      cy(2);
      fault_reset <= 1'b0;
      wr(OFS_IRQ, 32'h3);
   endtask : clr
   initial begin
      {aresetn, hazard, regen_request, fault_reset, want_regen} = '0;
      {want_demand, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
      {fails, tests_run} = '0;
      cy(4);
      aresetn <= 1'b1;
      cy(1);
      rd(OFS_POLICY);
      chk(d, 32'h1);
      rd(OFS_CODES);
      chk(d, {FAULT_CODE, ALARM_CODE});
      rd(8'h40);
      chk({d[29:0], r}, {30'h0, AXI_SLVERR});
      wr(8'h40, 32'h1);
      chk(r, AXI_SLVERR);
      wr(OFS_POLICY, 32'h0);
      rd(OFS_POLICY);
      chk(d, 32'h1);
      wr(OFS_MASK, 32'h3);
      {hazard, want_regen, want_demand, regen_request} <= 4'hF;
      cy(5);
      chk(outs, 4'h0);
      rd(OFS_IRQ);
      chk(d, 32'h0);
      clr();
      wr(OFS_POLICY, 32'h2);
      hazard <= 1'b1;
      cy(4);
      chk({outs, irq}, 5'h7);
      wr(OFS_IRQ, 32'h1);
      rd(OFS_IRQ);
      chk(d, 32'h0);
      regen_request <= 1'b1;
      cy(3);
      chk(outs, 4'h8);
      rd(OFS_IRQ);
      chk(d, 32'h2);
      clr();
      want_regen <= 1'b1;
      cy(2);
      hazard <= 1'b1;
      cy(3);
      chk(outs, 4'h8);
      clr();
      wr(OFS_POLICY, 32'h3);
      want_regen <= 1'b1;
      cy(2);
      hazard <= 1'b1;
      cy(3);
      chk(outs, 4'h7);
      want_demand <= 1'b1;
      cy(G - 5);
      chk(outs, 4'h7);
      want_demand <= 1'b0;
      cy(3);
      want_demand <= 1'b1;
      n = 0;
      while (!coast_or_brake_stop && n < 3 * G) begin
         cy(1);
         n++;
      end
      chk(n >= G - 1 && n <= G + 5, 1'b1);
      clr();
      hazard <= 1'b1;
      cy(3);
      chk(outs, 4'h3);
      regen_request <= 1'b1;
      cy(3);
      chk(outs, 4'h7);
      want_demand <= 1'b1;
      cy(G / 2);
      hazard <= 1'b0;
      cy(3);
      chk(outs, 4'h0);
      clr();
      print_verdict();
   end
endmodule : inverting_fault_avoidance_tb

// [hdl/ifa_supervisor.sv]
// What this block does
// - Policy 1 off, 2 trip, 3 grace; default off
// - Trip policy, hazard regenerating: stop, fault
// - Trip policy, hazard motoring: alarm, keep running
// - Trip policy, alarm then regen request: fault
// - Grace policy, hazard regenerating: zero reference, alarm
// - Grace policy motoring: alarm; regen opens grace
// - Grace window: motoring allowed, regen demand coasts
// - Regen demand past two seconds: stop, fault
// - Condition clears in time: resume, regen re-enabled
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
module ifa_supervisor
   import ifa_pkg::*;
#(
   parameter int GRACE_CYCLES = GRACE_TICKS
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        hazard,
   input  wire logic        regenerating,
   input  wire logic        regen_request,
   input  wire logic        regen_demand,
   input  wire logic        fault_reset,
   output logic             force_ref_zero,
   output logic             regen_bridge_off,
   output logic             coast_or_brake_stop,
   output logic             regen_hazard_event,
   output logic             alarm_active,
   output logic             irq,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // Grace count needs at least two cycles to tell entry from expiry
   if (GRACE_CYCLES < 2) begin : g_grace_check
      $error("GRACE_CYCLES out of range");
   end

   ifa_state_e  state;
   ifa_state_e  next_state;
   logic [31:0] grace_cnt;
   logic [31:0] next_grace_cnt;
   logic [1:0]  regen_hazard_policy;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;
   logic        fault_evt;
   logic        alarm_evt;
   logic        next_force_ref_zero;
   logic        next_regen_bridge_off;
   logic        next_stop;

   // Protection state machine
   always_comb begin
      next_state     = state;
      next_grace_cnt = grace_cnt;
      fault_evt      = 1'b0;
      alarm_evt      = 1'b0;
      unique case (state)
         IFA_NORMAL: begin
            if (hazard && regen_hazard_policy == POL_TRIP_NOW) begin
               if (regenerating || regen_request) begin
                  next_state = IFA_FAULT;
                  fault_evt  = 1'b1;
               end else begin
                  next_state = IFA_ALARM;
                  alarm_evt  = 1'b1;
               end
            end else if (hazard &&
                         regen_hazard_policy == POL_GRACE_TRIP) begin
               alarm_evt      = 1'b1;
               next_grace_cnt = 32'h0;
               next_state     = regenerating ? IFA_GRACE
                                             : IFA_ALARM;
            end
         end
         IFA_ALARM: begin
            if (regen_hazard_policy == POL_DISABLED) begin
               next_state = IFA_NORMAL;
            end else if (!hazard) begin
               next_state = IFA_NORMAL;
            end else if (regen_request || regenerating) begin
               if (regen_hazard_policy == POL_TRIP_NOW) begin
                  next_state = IFA_FAULT;
                  fault_evt  = 1'b1;
               end else begin
                  next_state     = IFA_GRACE;
                  next_grace_cnt = 32'h0;
               end
            end
         end
         IFA_GRACE: begin
            if (regen_hazard_policy == POL_DISABLED) begin
               next_state = IFA_NORMAL;
            end else if (!hazard) begin
               next_state     = IFA_NORMAL;
               next_grace_cnt = 32'h0;
            end else if (!regen_demand) begin
               next_grace_cnt = 32'h0;
            end else if (grace_cnt >= 32'(GRACE_CYCLES - 1)) begin
               next_state = IFA_FAULT;
               fault_evt  = 1'b1;
            end else begin
               next_grace_cnt = grace_cnt + 32'h1;
            end
         end
         IFA_FAULT: begin
            if (fault_reset) begin
               next_state = IFA_NORMAL;
            end
         end
      endcase
   end

   // Outputs toward the regulator and bridge
   always_comb begin
      next_stop             = next_state == IFA_FAULT;
      next_force_ref_zero   = next_state == IFA_GRACE;
      // Regen demand coasts, motoring current still allowed
      next_regen_bridge_off = next_state == IFA_ALARM ||
                              next_state == IFA_GRACE;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state               <= IFA_NORMAL;
         grace_cnt           <= 32'h0;
         coast_or_brake_stop <= 1'b0;
         force_ref_zero      <= 1'b0;
         regen_bridge_off    <= 1'b0;
         regen_hazard_event  <= 1'b0;
         alarm_active        <= 1'b0;
      end else begin
         state               <= next_state;
         grace_cnt           <= next_grace_cnt;
         coast_or_brake_stop <= next_stop;
         force_ref_zero      <= next_force_ref_zero;
         regen_bridge_off    <= next_regen_bridge_off;
         regen_hazard_event  <= fault_evt | alarm_evt;
         alarm_active        <= next_regen_bridge_off;
      end
   end

   // AXI4-Lite slave
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        next_aw_held;
   logic        next_w_held;
   logic [7:0]  next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   logic [1:0]  next_policy;
   logic [1:0]  next_irq_status;
   logic [1:0]  next_irq_mask;
   logic        do_write;
   logic        do_read;
   logic [1:0]  set_bits;
   logic [1:0]  clr_bits;
   logic [1:0]  wpol;

   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      next_policy  = regen_hazard_policy;
      next_irq_mask = irq_mask;
      clr_bits     = 2'h0;
      wpol         = w_data[1:0];
      // Address and data are taken only on a valid and ready handshake
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      do_write = aw_held && w_held && !s_axi_bvalid;
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = AXI_OKAY;
         unique case (aw_addr)
            OFS_POLICY: begin
               if (w_strb[0] && wpol != 2'h0) begin
                  next_policy = wpol;
               end
            end
            OFS_IRQ: begin
               if (w_strb[0]) begin
                  clr_bits = w_data[1:0];
               end
            end
            OFS_MASK: begin
               if (w_strb[0]) begin
                  next_irq_mask = w_data[1:0];
               end
            end
            OFS_STATUS, OFS_CODES: ;
            default: next_bresp = AXI_SLVERR;
         endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      do_read = s_axi_arvalid && s_axi_arready;
      if (do_read) begin
         next_rvalid = 1'b1;
         next_rresp  = AXI_OKAY;
         unique case (s_axi_araddr[7:0])
            OFS_POLICY: next_rdata = {30'h0, regen_hazard_policy};
            OFS_STATUS: next_rdata = {27'h0, coast_or_brake_stop,
                                      alarm_active, force_ref_zero,
                                      regen_bridge_off, hazard};
            OFS_IRQ:    next_rdata = {30'h0, irq_status};
            OFS_MASK:   next_rdata = {30'h0, irq_mask};
            OFS_CODES:  next_rdata = {FAULT_CODE, ALARM_CODE};
            default: begin
               next_rdata = 32'h0;
               next_rresp = AXI_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      set_bits = 2'h0;
      set_bits[IRQ_ALARM_BIT] = alarm_evt;
      set_bits[IRQ_FAULT_BIT] = fault_evt;
      // Set wins over a clear in the same cycle
      next_irq_status = (irq_status & ~clr_bits) | set_bits;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held             <= 1'b0;
         w_held              <= 1'b0;
         aw_addr             <= 8'h00;
         w_data              <= 32'h0;
         w_strb              <= 4'h0;
         s_axi_bvalid        <= 1'b0;
         s_axi_bresp         <= AXI_OKAY;
         s_axi_rvalid        <= 1'b0;
         s_axi_rdata         <= 32'h0;
         s_axi_rresp         <= AXI_OKAY;
         s_axi_awready       <= 1'b0;
         s_axi_wready        <= 1'b0;
         s_axi_arready       <= 1'b0;
         regen_hazard_policy <= POLICY_RESET;
         irq_status          <= 2'h0;
         irq_mask            <= MASK_RESET;
         irq                 <= 1'b0;
      end else begin
         aw_held             <= next_aw_held;
         w_held              <= next_w_held;
         aw_addr             <= next_aw_addr;
         w_data              <= next_w_data;
         w_strb              <= next_w_strb;
         s_axi_bvalid        <= next_bvalid;
         s_axi_bresp         <= next_bresp;
         s_axi_rvalid        <= next_rvalid;
         s_axi_rdata         <= next_rdata;
         s_axi_rresp         <= next_rresp;
         s_axi_awready       <= !next_aw_held;
         s_axi_wready        <= !next_w_held;
         s_axi_arready       <= !next_rvalid;
         regen_hazard_policy <= next_policy;
         irq_status          <= next_irq_status;
         irq_mask            <= next_irq_mask;
         irq                 <= |(next_irq_status & next_irq_mask);
      end
   end
endmodule : ifa_supervisor

// [inc/ifa_pkg.sv]
package ifa_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_POLICY = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ    = 8'h08;
   localparam logic [7:0] OFS_MASK   = 8'h0C;
   localparam logic [7:0] OFS_CODES  = 8'h10;
   // Policy encodings
   localparam logic [1:0] POL_DISABLED   = 2'h1;
   localparam logic [1:0] POL_TRIP_NOW   = 2'h2;
   localparam logic [1:0] POL_GRACE_TRIP = 2'h3;
   localparam logic [1:0] POLICY_RESET   = POL_DISABLED;
   // Interrupt bit positions
   localparam int IRQ_ALARM_BIT = 0;
   localparam int IRQ_FAULT_BIT = 1;
   localparam logic [1:0] MASK_RESET = 2'h0;
   // Event codes as reported
   localparam logic [15:0] FAULT_CODE = 16'h0015;
   localparam logic [15:0] ALARM_CODE = 16'h0005;
   // Timing
   localparam int CLK_MHZ     = 200;
   localparam int GRACE_MS    = 2000;
   localparam int GRACE_TICKS = GRACE_MS * 1000 * CLK_MHZ;
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      IFA_NORMAL = 2'b00,
      IFA_ALARM  = 2'b01,
      IFA_GRACE  = 2'b11,
      IFA_FAULT  = 2'b10
   } ifa_state_e;
endpackage : ifa_pkg
